// file: core/qs_defs.svh
// Constants for the identification query space and its serial read link
`ifndef QS_DEFS_SVH
`define QS_DEFS_SVH

`define QS_ADDR_W 16
`define QS_BLANK 8'hFF

// Latency code parameter
`define QS_LAT_BASE 16'h0100
`define QS_LAT_ID 8'h9A
`define QS_LAT_LEN 8'h2A
`define QS_LAT_ROWS 8'h05
`define QS_LAT_ROWLEN 8'h08
`define QS_LAT_HDR 64'h4643_0D0E_BDBE_EDEE
`define QS_LAT_ROW0 16'h000C
`define QS_LAT_LAST 16'h002B

// Rows: limit MHz, code, fast mode/dummy, dual mode/dummy, quad mode/dummy
`define QS_ROW_LC00 64'h4200_0402_0204_0106
`define QS_ROW_LC01 64'h4201_0404_0205_0107
`define QS_ROW_LC10 64'h4202_0405_0206_0108
`define QS_ROW_LC11 64'h3203_0401_0202_0103

// Padding parameter, placed right after the latency parameter
`define QS_PAD_ID 8'hF0
`define QS_PAD_FILL 8'hFF
`define QS_PAD_BASE 16'h012C
`define QS_PAD_LEN 8'h52

// Electronic marking area
`define QS_MARK_BASE 16'h0180
`define QS_MARK_REV_OFS 16'h0181
`define QS_LOT_OFS 16'h0182
`define QS_WAFER_OFS 16'h018A
`define QS_DIEX_OFS 16'h018B
`define QS_DIEY_OFS 16'h018C
`define QS_CLASS_OFS 16'h018D
`define QS_RSVD_OFS 16'h0194
`define QS_RSVD_END 16'h019F
`define QS_MARK_SIZE 8'h14
`define QS_MARK_REV 8'h01

`endif

// file: core/qs_pkg.sv
// Types and table lookup for the query space block
`include "qs_defs.svh"

package qs_pkg;

	typedef enum logic [1:0] {
		QS_IDLE = 2'b00,
		QS_ADDR = 2'b01,
		QS_LOAD = 2'b10,
		QS_DATA = 2'b11
	} qs_state_t;

	typedef logic [1:0] qs_lat_code_t;

	function automatic logic [63:0] qsLatRow(input qs_lat_code_t code);
		case (code)
			2'b00: qsLatRow = `QS_ROW_LC00;
			2'b01: qsLatRow = `QS_ROW_LC01;
			2'b10: qsLatRow = `QS_ROW_LC10;
			default: qsLatRow = `QS_ROW_LC11;
		endcase
	endfunction : qsLatRow

endpackage : qs_pkg

// file: core/qs_query_rom.sv
// Byte map of the identification query space
`include "qs_defs.svh"

module qs_query_rom #(
	parameter logic [63:0] LOT_NUMBER = 64'h5153_3030_3030_3031,
	parameter logic [7:0] WAFER = 8'h01,
	parameter logic [7:0] DIE_X = 8'h01,
	parameter logic [7:0] DIE_Y = 8'h01,
	parameter logic [55:0] CLASS_LOT = 56'h434C_3030_3030_31,
	parameter bit AUTOMOTIVE = 1'b1
) (
	input wire logic [15:0] addr,
	output logic [7:0] data
);
	import qs_pkg::*;

	// Header row as a named constant so that bytes can be selected from it
	localparam logic [63:0] LAT_HDR = `QS_LAT_HDR;

	logic [15:0] rel;
	logic [15:0] rowOfs;
	logic [63:0] row;
	logic [15:0] lotIdx;
	logic [15:0] classIdx;

	always_comb begin
		rel = addr - `QS_LAT_BASE;
		rowOfs = rel - `QS_LAT_ROW0;
		// Row k carries latency code k-1, so 11b first
		row = qsLatRow(qs_lat_code_t'(rowOfs[4:3] - 2'b01));
		lotIdx = addr - `QS_LOT_OFS;
		classIdx = addr - `QS_CLASS_OFS;
		data = `QS_BLANK;
		if (addr >= `QS_LAT_BASE && rel <= `QS_LAT_LAST) begin
			if (rel == 16'h0000) begin
				data = `QS_LAT_ID;
			end else if (rel == 16'h0001) begin
				data = `QS_LAT_LEN;
			end else if (rel == 16'h0002) begin
				data = `QS_LAT_ROWS;
			end else if (rel == 16'h0003) begin
				data = `QS_LAT_ROWLEN;
			end else if (rel < `QS_LAT_ROW0) begin
				data = LAT_HDR[8'd63 - {rel[2:0] ^ 3'h4, 3'h0} -: 8];
			end else begin
				data = row[8'd63 - {rowOfs[2:0], 3'h0} -: 8];
			end
		end else if (addr == `QS_PAD_BASE) begin
			data = `QS_PAD_ID;
		end else if (addr == `QS_PAD_BASE + 16'h0001) begin
			data = `QS_PAD_LEN;
		end else if (addr > `QS_PAD_BASE && addr < `QS_MARK_BASE) begin
			data = `QS_PAD_FILL;
		end else if (addr == `QS_MARK_BASE) begin
			data = `QS_MARK_SIZE;
		end else if (addr == `QS_MARK_REV_OFS) begin
			data = `QS_MARK_REV;
		end else if (addr >= `QS_LOT_OFS && addr < `QS_WAFER_OFS) begin
			data = LOT_NUMBER[8'd63 - {lotIdx[2:0], 3'h0} -: 8];
		end else if (addr == `QS_WAFER_OFS) begin
			data = WAFER;
		end else if (addr == `QS_DIEX_OFS) begin
			data = DIE_X;
		end else if (addr == `QS_DIEY_OFS) begin
			data = DIE_Y;
		end else if (AUTOMOTIVE && addr >= `QS_CLASS_OFS && addr < `QS_RSVD_OFS) begin
			data = CLASS_LOT[8'd55 - {classIdx[2:0], 3'h0} -: 8];
		end else begin
			data = `QS_BLANK;
		end
	end

endmodule : qs_query_rom

// file: core/qs_query_link.sv
// Serial read port of the identification query space with latency lookup
// What this block does
// - Code 00b up to 66 MHz gives fast DDR 4/2, dual DDR 2/4, quad DDR 1/6 mode/dummy.
// - Code 01b up to 66 MHz gives fast DDR 4/4, dual DDR 2/5, quad DDR 1/7 mode/dummy.
// - Code 10b up to 66 MHz gives fast DDR 4/5, dual DDR 2/6, quad DDR 1/8 mode/dummy.
// - Code 11b up to 50 MHz gives fast DDR 4/1, dual DDR 2/2, quad DDR 1/3 mode/dummy.
// - Each parameter has a length byte and the next one starts past it by that count.
// - Padding parameters F0h filled with FFh reserve space and align what follows.
// - Marking starts at 0180h with size, revision, then an eight-byte lot at 0182h.
// - Wafer at 018Ah, die X at 018Bh, die Y at 018Ch make the device unique with the lot.
// - Automotive parts add a seven-byte class lot at 018Dh and twelve FFh from 0194h.
`include "qs_defs.svh"

module qs_query_link #(
	parameter logic [63:0] LOT_NUMBER = 64'h5153_3030_3030_3031,
	parameter logic [7:0] WAFER = 8'h01,
	parameter logic [7:0] DIE_X = 8'h01,
	parameter logic [7:0] DIE_Y = 8'h01,
	parameter logic [55:0] CLASS_LOT = 56'h434C_3030_3030_31,
	parameter bit AUTOMOTIVE = 1'b1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sckPin,
	input wire logic csPinN,
	input wire logic mosiPin,
	input wire qs_pkg::qs_lat_code_t latencyCode,
	output logic misoOut,
	output logic misoOe,
	output logic [7:0] sckLimitMhz,
	output logic [3:0] fastModeCycles,
	output logic [3:0] fastDummyCycles,
	output logic [3:0] dualModeCycles,
	output logic [3:0] dualDummyCycles,
	output logic [3:0] quadModeCycles,
	output logic [3:0] quadDummyCycles
);
	import qs_pkg::*;

	// Pin synchronisers
	logic sckMeta, sckSync, sckPrev;
	logic csMeta, csSyncN;
	logic mosiMeta, mosiSync;
	logic sckRise, sckFall;

	always_ff @(posedge clock) begin
		if (rst) begin
			sckMeta <= 1'b0;
			sckSync <= 1'b0;
			sckPrev <= 1'b0;
			csMeta <= 1'b1;
			csSyncN <= 1'b1;
			mosiMeta <= 1'b0;
			mosiSync <= 1'b0;
		end else begin
			sckMeta <= sckPin;
			sckSync <= sckMeta;
			sckPrev <= sckSync;
			csMeta <= csPinN;
			csSyncN <= csMeta;
			mosiMeta <= mosiPin;
			mosiSync <= mosiMeta;
		end
	end

	assign sckRise = sckSync & ~sckPrev;
	assign sckFall = ~sckSync & sckPrev;

	// Link state
	qs_state_t state, next_state;
	logic [15:0] shiftIn, next_shiftIn;
	logic [15:0] addr, next_addr;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] outByte, next_outByte;
	logic next_misoOut, next_misoOe;
	logic [7:0] romData;
	logic byteLoad;

	qs_query_rom #(
		.LOT_NUMBER(LOT_NUMBER),
		.WAFER(WAFER),
		.DIE_X(DIE_X),
		.DIE_Y(DIE_Y),
		.CLASS_LOT(CLASS_LOT),
		.AUTOMOTIVE(AUTOMOTIVE)
	) u_rom (
		.addr(addr),
		.data(romData)
	);

	always_comb begin
		next_state = state;
		next_shiftIn = shiftIn;
		next_addr = addr;
		next_bitCnt = bitCnt;
		next_outByte = outByte;
		next_misoOut = misoOut;
		next_misoOe = misoOe;
		byteLoad = 1'b0;
		if (csSyncN) begin
			next_state = QS_IDLE;
			next_misoOut = 1'b0;
			next_misoOe = 1'b0;
		end else begin
			case (state)
				QS_IDLE: begin
					next_state = QS_ADDR;
					next_bitCnt = 4'h0;
				end
				QS_ADDR: begin
					if (sckRise) begin
						next_shiftIn = {shiftIn[14:0], mosiSync};
						next_bitCnt = bitCnt + 4'h1;
						if (bitCnt == 4'hF) begin
							next_addr = {shiftIn[14:0], mosiSync};
							next_state = QS_LOAD;
						end
					end
				end
				QS_LOAD: begin
					// First bit of each byte goes out on the falling edge
					if (sckFall) begin
						byteLoad = 1'b1;
						next_outByte = romData;
						next_misoOut = romData[7];
						next_misoOe = 1'b1;
						next_addr = addr + 16'h0001;
						next_bitCnt = 4'h6;
						next_state = QS_DATA;
					end
				end
				QS_DATA: begin
					if (sckFall) begin
						next_misoOut = outByte[bitCnt[2:0]];
						next_bitCnt = bitCnt - 4'h1;
						if (bitCnt == 4'h0) begin
							next_state = QS_LOAD;
						end
					end
				end
				default: begin
					next_state = QS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= QS_IDLE;
			shiftIn <= 16'h0000;
			addr <= 16'h0000;
			bitCnt <= 4'h0;
			outByte <= 8'h00;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			state <= next_state;
			shiftIn <= next_shiftIn;
			addr <= next_addr;
			bitCnt <= next_bitCnt;
			outByte <= next_outByte;
			misoOut <= next_misoOut;
			misoOe <= next_misoOe;
		end
	end

	// Latency lookup for the selected code
	logic [63:0] latRow;
	logic [7:0] next_sckLimitMhz;
	logic [3:0] next_fastMode, next_fastDummy, next_dualMode;
	logic [3:0] next_dualDummy, next_quadMode, next_quadDummy;

	always_comb begin
		latRow = qsLatRow(latencyCode);
		next_sckLimitMhz = latRow[63:56];
		next_fastMode = latRow[43:40];
		next_fastDummy = latRow[35:32];
		next_dualMode = latRow[27:24];
		next_dualDummy = latRow[19:16];
		next_quadMode = latRow[11:8];
		next_quadDummy = latRow[3:0];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sckLimitMhz <= 8'h00;
			fastModeCycles <= 4'h0;
			fastDummyCycles <= 4'h0;
			dualModeCycles <= 4'h0;
			dualDummyCycles <= 4'h0;
			quadModeCycles <= 4'h0;
			quadDummyCycles <= 4'h0;
		end else begin
			sckLimitMhz <= next_sckLimitMhz;
			fastModeCycles <= next_fastMode;
			fastDummyCycles <= next_fastDummy;
			dualModeCycles <= next_dualMode;
			dualDummyCycles <= next_dualDummy;
			quadModeCycles <= next_quadMode;
			quadDummyCycles <= next_quadDummy;
		end
	end

	// Checks
	sequence loadAt(logic [15:0] a);
		byteLoad && addr == a;
	endsequence

	sequence codeHeld(qs_lat_code_t c);
		latencyCode == c ##1 latencyCode == c;
	endsequence

	lat_code00_a: assert property (@(posedge clock) disable iff (rst)
		codeHeld(2'b00) |-> sckLimitMhz == 8'h42 && fastModeCycles == 4'h4
		&& fastDummyCycles == 4'h2 && dualModeCycles == 4'h2 && dualDummyCycles == 4'h4
		&& quadModeCycles == 4'h1 && quadDummyCycles == 4'h6)
		else $error("latency code 00b values wrong");

	lat_code01_a: assert property (@(posedge clock) disable iff (rst)
		codeHeld(2'b01) |-> sckLimitMhz == 8'h42 && fastDummyCycles == 4'h4
		&& dualDummyCycles == 4'h5 && quadDummyCycles == 4'h7 && quadModeCycles == 4'h1)
		else $error("latency code 01b values wrong");

	lat_code10_a: assert property (@(posedge clock) disable iff (rst)
		codeHeld(2'b10) |-> sckLimitMhz == 8'h42 && fastDummyCycles == 4'h5
		&& dualDummyCycles == 4'h6 && quadDummyCycles == 4'h8 && dualModeCycles == 4'h2)
		else $error("latency code 10b values wrong");

	lat_code11_a: assert property (@(posedge clock) disable iff (rst)
		codeHeld(2'b11) |-> sckLimitMhz == 8'h32 && fastModeCycles == 4'h4
		&& fastDummyCycles == 4'h1 && dualDummyCycles == 4'h2 && quadDummyCycles == 4'h3)
		else $error("latency code 11b values wrong");

	param_chain_a: assert property (@(posedge clock) disable iff (rst)
		loadAt(`QS_LAT_BASE + 16'h0001) |=> outByte == `QS_LAT_LEN
		&& `QS_PAD_BASE == `QS_LAT_BASE + 16'h0002 + {8'h00, `QS_LAT_LEN})
		else $error("latency parameter length does not reach padding");

	pad_body_a: assert property (@(posedge clock) disable iff (rst)
		byteLoad && addr > `QS_PAD_BASE + 16'h0001 && addr < `QS_MARK_BASE
		|=> outByte == `QS_PAD_FILL && misoOut && misoOe)
		else $error("padding body byte not FFh");

	mark_head_a: assert property (@(posedge clock) disable iff (rst)
		loadAt(`QS_MARK_BASE) |=> outByte == `QS_MARK_SIZE
		&& `QS_MARK_BASE == `QS_PAD_BASE + 16'h0002 + {8'h00, `QS_PAD_LEN})
		else $error("marking size byte wrong or misaligned");

	lot_first_a: assert property (@(posedge clock) disable iff (rst)
		loadAt(`QS_LOT_OFS) |=> outByte == LOT_NUMBER[63:56])
		else $error("lot number first byte wrong");

	die_ident_a: assert property (@(posedge clock) disable iff (rst)
		loadAt(`QS_DIEY_OFS) |=> outByte == DIE_Y)
		else $error("die Y byte wrong");

	rsvd_fill_a: assert property (@(posedge clock) disable iff (rst)
		byteLoad && addr >= `QS_RSVD_OFS && addr <= `QS_RSVD_END |=> outByte == `QS_BLANK)
		else $error("reserved marking byte not FFh");

	bit_order_a: assert property (@(posedge clock) disable iff (rst)
		byteLoad ##1 (!sckFall && !csSyncN) [*2] |-> misoOut == outByte[7])
		else $error("first data bit is not the byte MSB");

endmodule : qs_query_link

// file: verif/qs_host_model.sv
// Host side model of the serial read link, mode 0
module qs_host_model (
	input wire logic clock,
	input wire logic misoOut,
	input wire logic misoOe,
	output logic sckPin,
	output logic csPinN,
	output logic mosiPin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rxBytes [0:127];
	logic oeSeen;

	initial begin
		sckPin = 1'b0;
		csPinN = 1'b1;
		mosiPin = 1'b0;
	end

	// Half of an 80 ns link period; far below every row's ceiling
	task automatic halfBit();
		repeat (5) @(negedge clock);
	endtask : halfBit

	// Fewer than 16 address bits aborts the frame
	task automatic readBytes(input logic [15:0] addr, input int count, input int bits);
		int i;
		int b;
		oeSeen = 1'b1;
		@(negedge clock);
		csPinN = 1'b0;
		repeat (4) @(negedge clock);
		for (i = 15; i >= 16 - bits; i--) begin
			mosiPin = addr[i];
			halfBit();
			sckPin = 1'b1;
			halfBit();
			sckPin = 1'b0;
		end
		for (i = 0; i < count; i++) begin
			for (b = 7; b >= 0; b--) begin
				mosiPin = ~mosiPin;
				halfBit();
				oeSeen = oeSeen & misoOe;
				rxBytes[i][b] = misoOut;
				sckPin = 1'b1;
				halfBit();
				sckPin = 1'b0;
			end
		end
		csPinN = 1'b1;
	endtask : readBytes
endmodule : qs_host_model

// file: verif/qs_query_link_tb.sv
// Self-checking bench for the query space serial link
module qs_query_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qs_pkg::*;
	localparam logic [63:0] LOT = 64'h4C44_3837_3237_30FF;
	localparam logic [55:0] CLS = 56'h4252_3333_3135_30;
	logic clock, rst, sckPin, csPinN, mosiPin, misoOut, misoOe;
	qs_lat_code_t latencyCode;
	logic [7:0] sckLimitMhz;
	logic [3:0] fastModeCycles, fastDummyCycles, dualModeCycles;
	logic [3:0] dualDummyCycles, quadModeCycles, quadDummyCycles;
	int errTotal = 0;
	int samplesChecked = 0;

	qs_query_link #(.LOT_NUMBER(LOT), .WAFER(8'h17), .DIE_X(8'h0A), .DIE_Y(8'h0F),
		.CLASS_LOT(CLS), .AUTOMOTIVE(1'b1)) u_qs_query_link (
		.clock(clock), .rst(rst), .sckPin(sckPin), .csPinN(csPinN), .mosiPin(mosiPin),
		.latencyCode(latencyCode), .misoOut(misoOut), .misoOe(misoOe),
		.sckLimitMhz(sckLimitMhz), .fastModeCycles(fastModeCycles),
		.fastDummyCycles(fastDummyCycles), .dualModeCycles(dualModeCycles),
		.dualDummyCycles(dualDummyCycles), .quadModeCycles(quadModeCycles),
		.quadDummyCycles(quadDummyCycles)
	);

	qs_host_model u_qs_host_model (
		.clock(clock), .misoOut(misoOut), .misoOe(misoOe),
		.sckPin(sckPin), .csPinN(csPinN), .mosiPin(mosiPin)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("Checks made: %0d, mismatches: %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// Limit, fast, dual, quad mode/dummy per code
	function automatic logic [31:0] latRow(input logic [1:0] code);
		case (code)
			2'b00: latRow = 32'h4242_2416;
			2'b01: latRow = 32'h4244_2517;
			2'b10: latRow = 32'h4245_2618;
			default: latRow = 32'h3241_2213;
		endcase
	endfunction : latRow

	function automatic logic [63:0] grab(input int first, input int n);
		grab = 64'h0;
		for (int i = 0; i < n; i++) begin
			grab = {grab[55:0], u_qs_host_model.rxBytes[first + i]};
		end
	endfunction : grab

	task automatic endFrame();
		repeat (6) @(negedge clock);
		check(misoOe, 1'b0);
		check(misoOut, 1'b0);
	endtask : endFrame

	task automatic test_latency();
		logic [1:0] order [4] = '{2'b11, 2'b00, 2'b10, 2'b01};
		logic [31:0] r;
		for (int k = 0; k < 4; k++) begin
			latencyCode = order[k];
			r = latRow(order[k]);
			// Hold each code over two edges so the held-code checks see it
			repeat (2) @(negedge clock);
			check({sckLimitMhz, fastModeCycles, fastDummyCycles, dualModeCycles,
				dualDummyCycles, quadModeCycles, quadDummyCycles}, r);
		end
	endtask : test_latency

	task automatic test_param();
		logic [1:0] rowCode [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
		logic [31:0] r;
		u_qs_host_model.readBytes(16'h0100, 46, 16);
		check(u_qs_host_model.oeSeen, 1'b1);
		check(grab(0, 4), 64'h9A2A_0508);
		for (int k = 0; k < 4; k++) begin
			r = latRow(rowCode[k]);
			check(grab(12 + 8 * k, 8), {r[31:24], 6'h0, rowCode[k], 4'h0, r[23:20], 4'h0,
				r[19:16], 4'h0, r[15:12], 4'h0, r[11:8], 4'h0, r[7:4], 4'h0, r[3:0]});
		end
		check(u_qs_host_model.rxBytes[44], 8'hF0);
		endFrame();
	endtask : test_param

	task automatic test_pad();
		int len;
		len = 16'h0180 - 16'h012D - 1;
		u_qs_host_model.readBytes(16'h012D, len + 2, 16);
		check(u_qs_host_model.rxBytes[0], len[7:0]);
		for (int i = 1; i <= len; i++) begin
			check(u_qs_host_model.rxBytes[i], 8'hFF);
		end
		check(u_qs_host_model.rxBytes[len + 1], 8'h14);
		endFrame();
	endtask : test_pad

	task automatic test_abort();
		u_qs_host_model.readBytes(16'h0180, 0, 8);
		endFrame();
		u_qs_host_model.readBytes(16'h0181, 1, 16);
		check(u_qs_host_model.rxBytes[0], 8'h01);
		endFrame();
	endtask : test_abort

	task automatic test_mark();
		u_qs_host_model.readBytes(16'h0180, 32, 16);
		check(grab(0, 2), 64'h1401);
		check(grab(2, 8), LOT);
		check(grab(10, 3), 64'h170A0F);
		check(grab(13, 7), {8'h00, CLS});
		for (int i = 20; i < 32; i++) begin
			check(u_qs_host_model.rxBytes[i], 8'hFF);
		end
		endFrame();
	endtask : test_mark

	initial begin
		rst = 1'b1;
		latencyCode = 2'b00;
		repeat (16) @(negedge clock);
		check(misoOe, 1'b0);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		test_latency();
		test_param();
		test_pad();
		test_abort();
		test_mark();
		summarize();
	end

	initial begin
		#400000;
		errTotal++;
		summarize();
	end
endmodule : qs_query_link_tb
